// File: logic/pcr_pkg.sv
// constants for the pacing rate controller
//
// Overview of operation
// R1: auto gain raises gain one step if 90% max sensor rate lacks 1 hour weekly.
// R2: auto gain lowers gain one step after 1 hour at 90% within 24 hours.
// R3: activity at or below the sensor threshold has no effect on sensor rate.
// R4: sensor rate is clamped to max sensor rate, also the auto gain reference.
// R5: pacing rate follows sensor rate by at most the increase or decrease step per cycle.
// R6: rate smoothing is always on; fading and stabilization are selectable.
// R7: fading steps smooth night changes, mode switch entry/exit, post switch and post shock ends.
// R8: after four consecutive atrial senses the backup target becomes atrial rate minus 10 bpm.
// R9: premature atrial sense or atrial pace resets backup target to basic or sensor rate.
// R10: with fading on, a background backup rate is kept and paced at when rate falls.
// R11: backup rate rises 1, 2, 4, 8 bpm or falls 0.1, 0.2, 0.5, 1.0 bpm per cycle.
// R12: stabilized mode switch targets sensor or basic rate; ventricle paces at backup rate.
// R13: four consecutive faster intrinsic cycles are needed before pacing aligns to intrinsic rhythm.
// R14: isolated senses leave the stabilization target alone; four in a row activate it.
// R15: every sense or pace starts the basic interval; expiry without sense delivers a pace.
// R16: a sense after refractory suppresses the pace and restarts; refractory senses do not.
// R17: fixed rate ventricular and dual chamber modes ignore senses for inhibit and restart.
// R18: atrial controlled modes restart on atrial events, dual ones also on a premature ventricular beat.
// R19: ventricular controlled modes restart on any ventricular sensed or paced event.
// R20: night function swaps basic and hysteresis rates to night values between start and end.
// R21: with rate adaptation on, the night raises the sensor threshold one increment.
// R22: at night end the daytime basic rate returns through a smoothed transition.
// R23: step limits apply once per completed cycle; the rate then sets the interval timer.
// R24: sensor rate is basic rate plus above-threshold activity times gain, before clamping.
package pcr_pkg;
	// clock and time base
	localparam int unsigned CORE_CLK_HZ = 50_000_000;
	localparam int unsigned TICK_MS = 1;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned CYC_PER_MS_DFLT = CORE_CLK_HZ / MS_PER_S * TICK_MS;
	localparam int unsigned S_PER_MIN = 60;
	localparam int unsigned MIN_PER_DAY = 1440;
	localparam int unsigned HOUR_S = 3600;
	localparam int unsigned DAY_S = 86400;
	localparam int unsigned WEEK_S = 604800;
	// rates are in tenths of a bpm; interval numerator is 60000 ms times ten
	localparam logic [19:0] INTERVAL_NUM = 20'h927C0;
	localparam logic [11:0] TARGET_OFFSET = 12'h064;
	localparam logic [3:0] GAIN_MIN = 4'h1;
	localparam logic [3:0] GAIN_MAX = 4'hF;
	localparam logic [2:0] RUN_LEN = 3'h4;
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RATES = 8'h04;
	localparam logic [7:0] REG_SENSOR = 8'h08;
	localparam logic [7:0] REG_STEPS = 8'h0C;
	localparam logic [7:0] REG_NIGHT = 8'h10;
	localparam logic [7:0] REG_REFR = 8'h14;
	localparam logic [7:0] REG_TOD = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1C;
	localparam logic [7:0] REG_STAT2 = 8'h20;
	localparam logic [7:0] REG_HYST = 8'h24;
	// mode codes in CTRL[7:5]
	localparam logic [2:0] MODE_VENT = 3'h0;
	localparam logic [2:0] MODE_ATRIAL = 3'h1;
	localparam logic [2:0] MODE_DUAL = 3'h2;
	localparam logic [2:0] MODE_FIXED_RATE_VENTRICULAR = 3'h3;
	localparam logic [2:0] MODE_FIXED_RATE_DUAL_CHAMBER = 3'h4;
	// values after reset
	localparam logic [11:0] BASIC_RST = 12'h258;
	localparam logic [11:0] NIGHT_RATE_RST = 12'h1F4;
	localparam logic [11:0] MSR_RST = 12'h4B0;
	localparam logic [7:0] THR_RST = 8'h08;
	localparam logic [3:0] GAIN_RST = 4'h4;
	localparam logic [7:0] SINC_RST = 8'h14;
	localparam logic [7:0] SDEC_RST = 8'h05;
	localparam logic [9:0] REFR_RST = 10'h0FA;
	localparam logic [10:0] NSTART_RST = 11'h528;
	localparam logic [10:0] NEND_RST = 11'h168;
endpackage

// File: logic/pcr_rate_ctrl.sv
// pacing rate controller: sensor rate, step limits, fading backup rate, basic interval timer
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pcr_rate_ctrl import pcr_pkg::*; #(
	parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// detector and accelerometer pins
	input wire logic ATRIAL_SENSED_EVENT,
	input wire logic ATRIAL_PREMATURE_EVENT,
	input wire logic VENT_SENSED_EVENT,
	input wire logic PREMATURE_VENT_EVENT,
	input wire logic MODE_SWITCH_ACTIVE,
	input wire logic POST_MODE_SWITCH_ACTIVE,
	input wire logic POST_SHOCK_ACTIVE,
	input wire logic [7:0] ACTIVITY_LEVEL,
	// pacing outputs
	output logic ATRIAL_PACED_EVENT,
	output logic VENT_PACED_EVENT,
	output logic NIGHT_ACTIVE
);
	typedef enum logic {DIV_IDLE, DIV_RUN} pcr_div_e;

	typedef struct packed {
		logic [2:0] as_s;
		logic [2:0] aes_s;
		logic [2:0] vs_s;
		logic [2:0] pvc_s;
		logic [2:0] msw_s;
		logic [2:0] pms_s;
		logic [2:0] psh_s;
		logic [7:0] act_m;
		logic [7:0] act_s;
		logic ra_en;
		logic ag_en;
		logic fade_en;
		logic stab_en;
		logic night_en;
		logic [2:0] mode;
		logic [11:0] basic;
		logic [11:0] night_rate;
		logic [11:0] hyst;
		logic [11:0] night_hyst;
		logic [11:0] msr;
		logic [7:0] thr;
		logic [3:0] gain;
		logic [7:0] s_inc;
		logic [7:0] s_dec;
		logic [1:0] f_inc;
		logic [1:0] f_dec;
		logic [10:0] n_start;
		logic [10:0] n_end;
		logic [9:0] refr;
		logic [19:0] cyc_cnt;
		logic [9:0] ms_cnt;
		logic [5:0] sec_cnt;
		logic [10:0] tod;
		logic [16:0] day_s;
		logic [19:0] week_s;
		logic [11:0] hi_day;
		logic [11:0] hi_week;
		logic night;
		logic smooth;
		logic last_sensed;
		logic [2:0] run_cnt;
		logic [11:0] rate;
		logic [11:0] backup;
		logic [11:0] target;
		logic [11:0] atr_rate;
		logic [11:0] atr_ms;
		logic [19:0] acc;
		logic [9:0] since;
		pcr_div_e div_st;
		logic [4:0] div_cnt;
		logic [19:0] div_rem;
		logic [19:0] div_quo;
		logic [11:0] div_dvs;
		logic pace_a;
		logic pace_v;
		logic [31:0] rdata;
	} pcr_state_s;

	pcr_state_s st_q;
	pcr_state_s st_d;

	// rising edge of a synchronised pin, looking only at the second and third stage
	function automatic logic rise(input logic [2:0] s);
		return s[1] & ~s[2];
	endfunction

	function automatic logic falls(input logic [2:0] s);
		return ~s[1] & s[2];
	endfunction

	// move cur toward tgt by at most up or dn
	function automatic logic [11:0] step_to(input logic [11:0] cur, input logic [11:0] tgt,
			input logic [7:0] up, input logic [7:0] dn);
		logic [12:0] sum;
		sum = {1'b0, cur} + {5'h00, up};
		if (tgt > cur) begin
			return (sum >= {1'b0, tgt}) ? tgt : sum[11:0];
		end else if (cur - tgt > {4'h0, dn}) begin
			return cur - {4'h0, dn};
		end
		return tgt;
	endfunction

	// fading increase 1, 2, 4, 8 bpm and decrease 0.1, 0.2, 0.5, 1.0 bpm
	function automatic logic [7:0] fade_step(input logic [1:0] sel, input logic up);
		unique case (sel)
			2'h0: return up ? 8'h0A : 8'h01;
			2'h1: return up ? 8'h14 : 8'h02;
			2'h2: return up ? 8'h28 : 8'h05;
			2'h3: return up ? 8'h50 : 8'h0A;
		endcase
	endfunction

	always_comb begin
		logic tick_ms;
		logic tick_s;
		logic tick_min;
		logic in_win;
		logic night_now;
		logic as_e;
		logic aes_e;
		logic vs_e;
		logic pvc_e;
		logic msw;
		logic ms_stab;
		logic async_m;
		logic atrial_ctl;
		logic sense_ev;
		logic sense_ok;
		logic expire;
		logic hi;
		logic [7:0] thr_eff;
		logic [7:0] over;
		logic [11:0] prod;
		logic [12:0] raw;
		logic [11:0] base;
		logic [11:0] hyst_eff;
		logic [11:0] sens;
		logic [11:0] tgt_rate;
		logic [11:0] esc;
		logic [7:0] up;
		logic [7:0] dn;
		logic [20:0] acc_sum;
		logic [19:0] rem_sh;
		tick_ms = 1'b0;
		tick_s = 1'b0;
		tick_min = 1'b0;
		in_win = 1'b0;
		night_now = 1'b0;
		as_e = 1'b0;
		aes_e = 1'b0;
		vs_e = 1'b0;
		pvc_e = 1'b0;
		msw = 1'b0;
		ms_stab = 1'b0;
		async_m = 1'b0;
		atrial_ctl = 1'b0;
		sense_ev = 1'b0;
		sense_ok = 1'b0;
		expire = 1'b0;
		hi = 1'b0;
		thr_eff = '0;
		over = '0;
		prod = '0;
		raw = '0;
		base = '0;
		hyst_eff = '0;
		sens = '0;
		tgt_rate = '0;
		esc = '0;
		up = '0;
		dn = '0;
		acc_sum = '0;
		rem_sh = '0;
		st_d = st_q;
		st_d.pace_a = 1'b0;
		st_d.pace_v = 1'b0;

		// pins pass two flip-flops, the third stage only feeds edge detection
		st_d.as_s = {st_q.as_s[1:0], ATRIAL_SENSED_EVENT};
		st_d.aes_s = {st_q.aes_s[1:0], ATRIAL_PREMATURE_EVENT};
		st_d.vs_s = {st_q.vs_s[1:0], VENT_SENSED_EVENT};
		st_d.pvc_s = {st_q.pvc_s[1:0], PREMATURE_VENT_EVENT};
		st_d.msw_s = {st_q.msw_s[1:0], MODE_SWITCH_ACTIVE};
		st_d.pms_s = {st_q.pms_s[1:0], POST_MODE_SWITCH_ACTIVE};
		st_d.psh_s = {st_q.psh_s[1:0], POST_SHOCK_ACTIVE};
		st_d.act_m = ACTIVITY_LEVEL;
		st_d.act_s = st_q.act_m;
		as_e = rise(st_q.as_s);
		aes_e = rise(st_q.aes_s);
		vs_e = rise(st_q.vs_s);
		pvc_e = rise(st_q.pvc_s);
		msw = st_q.msw_s[1];

		// time base: ms, s, minute of day
		tick_ms = (st_q.cyc_cnt == 20'(CYC_PER_MS - 1));
		tick_s = tick_ms && (st_q.ms_cnt == 10'(MS_PER_S - 1));
		tick_min = tick_s && (st_q.sec_cnt == 6'(S_PER_MIN - 1));
		st_d.cyc_cnt = tick_ms ? '0 : st_q.cyc_cnt + 20'h00001;
		if (tick_ms) begin
			st_d.ms_cnt = tick_s ? '0 : st_q.ms_cnt + 10'h001;
		end
		if (tick_s) begin
			st_d.sec_cnt = tick_min ? '0 : st_q.sec_cnt + 6'h01;
		end
		if (tick_min) begin
			st_d.tod = (st_q.tod == 11'(MIN_PER_DAY - 1)) ? '0 : st_q.tod + 11'h001;
		end

		// night window may wrap past midnight
		if (st_q.n_start <= st_q.n_end) begin
			in_win = (st_q.tod >= st_q.n_start) && (st_q.tod < st_q.n_end);
		end else begin
			in_win = (st_q.tod >= st_q.n_start) || (st_q.tod < st_q.n_end);
		end
		night_now = st_q.night_en && in_win;
		st_d.night = night_now;
		base = st_q.night ? st_q.night_rate : st_q.basic; // see R20
		hyst_eff = st_q.night ? st_q.night_hyst : st_q.hyst; // see R20

		// sensor rate
		thr_eff = st_q.thr;
		if (st_q.night && st_q.ra_en && st_q.thr != 8'hFF) begin
			thr_eff = st_q.thr + 8'h01; // see R21
		end
		over = (st_q.act_s > thr_eff) ? st_q.act_s - thr_eff : 8'h00; // see R3
		prod = {4'h0, over} * {8'h00, st_q.gain};
		raw = {1'b0, base} + {1'b0, prod}; // see R24
		sens = (raw > {1'b0, st_q.msr}) ? st_q.msr : raw[11:0]; // see R4
		tgt_rate = st_q.ra_en ? sens : base;

		// pacing mode decode; mode switching hands control to the ventricle
		async_m = (st_q.mode == MODE_FIXED_RATE_VENTRICULAR) ||
			(st_q.mode == MODE_FIXED_RATE_DUAL_CHAMBER);
		ms_stab = msw && st_q.stab_en;
		atrial_ctl = ((st_q.mode == MODE_ATRIAL) || (st_q.mode == MODE_DUAL)) && !msw;
		if (async_m) begin
			sense_ev = 1'b0; // see R17
		end else if (atrial_ctl) begin
			sense_ev = as_e || aes_e || ((st_q.mode == MODE_DUAL) && pvc_e); // see R18
		end else begin
			sense_ev = vs_e || pvc_e; // see R19
		end
		sense_ok = sense_ev && (st_q.since >= st_q.refr); // see R16

		// escape rate: backup takes over when the pacing rate falls below it
		if (ms_stab) begin
			esc = st_q.backup; // see R12
		end else if (st_q.fade_en && st_q.backup > st_q.rate) begin
			esc = st_q.backup; // see R10
		end else begin
			esc = st_q.rate;
		end
		if (!ms_stab && st_q.last_sensed && hyst_eff != 12'h000 && hyst_eff < esc) begin
			esc = hyst_eff;
		end

		// phase accumulator replaces a rate-to-interval divider
		acc_sum = {1'b0, st_q.acc} + {9'h000, esc};
		expire = tick_ms && (acc_sum >= {1'b0, INTERVAL_NUM}); // see R23
		if (tick_ms) begin
			st_d.acc = acc_sum[19:0];
			st_d.since = (st_q.since == 10'h3FF) ? st_q.since : st_q.since + 10'h001;
			st_d.atr_ms = (st_q.atr_ms == 12'hFFF) ? st_q.atr_ms : st_q.atr_ms + 12'h001;
		end

		if (sense_ok || expire) begin
			// a valid sense in the same cycle as expiry wins and suppresses the pace
			st_d.acc = '0; // see R15
			st_d.since = '0;
			st_d.last_sensed = sense_ok;
			if (!sense_ok) begin
				st_d.pace_a = !async_m ? atrial_ctl :
					(st_q.mode == MODE_FIXED_RATE_DUAL_CHAMBER); // see R15
				st_d.pace_v = !atrial_ctl; // see R15
			end
			// smoothing steps use the fading settings; it can never be switched off
			up = st_q.smooth ? fade_step(st_q.f_inc, 1'b1) : st_q.s_inc; // see R6
			dn = st_q.smooth ? fade_step(st_q.f_dec, 1'b0) : st_q.s_dec; // see R7
			st_d.rate = step_to(st_q.rate, tgt_rate, up, dn); // see R5
			st_d.backup = step_to(st_q.backup, st_q.target,
				fade_step(st_q.f_inc, 1'b1), fade_step(st_q.f_dec, 1'b0)); // see R11
			if (st_q.smooth && st_d.rate == tgt_rate) begin
				st_d.smooth = 1'b0;
			end
			if (sense_ok && (as_e || vs_e)) begin
				st_d.run_cnt = (st_q.run_cnt == RUN_LEN) ? RUN_LEN : st_q.run_cnt + 3'h1;
			end else begin
				st_d.run_cnt = '0; // see R14
			end
		end

		// backup target
		if (aes_e || st_q.pace_a || ms_stab) begin
			st_d.target = tgt_rate; // see R9
			st_d.run_cnt = ms_stab ? st_d.run_cnt : '0;
		end

		// atrial rate from the last atrial sense interval, by shift and subtract
		if (as_e && sense_ok) begin
			st_d.atr_ms = '0;
			st_d.div_st = DIV_RUN;
			st_d.div_cnt = '0;
			st_d.div_rem = '0;
			st_d.div_quo = INTERVAL_NUM;
			st_d.div_dvs = (st_q.atr_ms == 12'h000) ? 12'h001 : st_q.atr_ms;
		end else if (st_q.div_st == DIV_RUN) begin
			rem_sh = {st_q.div_rem[18:0], st_q.div_quo[19]};
			if (rem_sh >= {8'h00, st_q.div_dvs}) begin
				st_d.div_rem = rem_sh - {8'h00, st_q.div_dvs};
				st_d.div_quo = {st_q.div_quo[18:0], 1'b1};
			end else begin
				st_d.div_rem = rem_sh;
				st_d.div_quo = {st_q.div_quo[18:0], 1'b0};
			end
			st_d.div_cnt = st_q.div_cnt + 5'h01;
			if (st_q.div_cnt == 5'h13) begin
				st_d.div_st = DIV_IDLE;
				st_d.atr_rate = (st_d.div_quo > 20'h00FFF) ? 12'hFFF : st_d.div_quo[11:0];
				// isolated senses are ignored until a run of four has been seen
				if (st_q.run_cnt == RUN_LEN && !ms_stab) begin
					st_d.target = (st_d.atr_rate > TARGET_OFFSET) ?
						st_d.atr_rate - TARGET_OFFSET : 12'h000; // see R8
					if (st_q.backup > st_d.atr_rate) begin
						st_d.backup = st_d.atr_rate; // see R13
					end
				end
			end
		end

		// smoothed transitions; the set wins over the clear above
		if ((night_now != st_q.night) || rise(st_q.msw_s) || falls(st_q.msw_s) ||
				falls(st_q.pms_s) || falls(st_q.psh_s)) begin
			st_d.smooth = 1'b1; // see R7
			if (st_q.night && !night_now) begin
				st_d.smooth = 1'b1; // see R22
			end
		end

		// automatic gain, judged against 90% of the maximum sensor rate
		if (tick_s) begin
			hi = (16'(st_q.rate) * 16'h000A) >= (16'(st_q.msr) * 16'h0009); // see R4
			st_d.day_s = st_q.day_s + 17'h00001;
			st_d.week_s = st_q.week_s + 20'h00001;
			if (st_q.ag_en && hi) begin
				st_d.hi_day = st_q.hi_day + 12'h001;
				st_d.hi_week = (st_q.hi_week == 12'(HOUR_S)) ? st_q.hi_week :
					st_q.hi_week + 12'h001;
			end
			if (st_q.ag_en && st_d.hi_day == 12'(HOUR_S)) begin
				st_d.gain = (st_q.gain > GAIN_MIN) ? st_q.gain - 4'h1 : st_q.gain; // see R2
				st_d.hi_day = '0;
				st_d.day_s = '0;
			end else if (st_q.day_s == 17'(DAY_S - 1)) begin
				st_d.day_s = '0;
				st_d.hi_day = '0;
			end
			if (st_q.week_s == 20'(WEEK_S - 1)) begin
				if (st_q.ag_en && st_q.hi_week < 12'(HOUR_S)) begin
					st_d.gain = (st_q.gain < GAIN_MAX) ? st_q.gain + 4'h1 : st_q.gain; // see R1
				end
				st_d.week_s = '0;
				st_d.hi_week = '0;
			end
		end

		// register writes; software overrides the automatic gain
		if (WR) begin
			unique case (ADDR)
				REG_CTRL: begin
					{st_d.mode, st_d.night_en, st_d.stab_en} = WDATA[7:3];
					{st_d.fade_en, st_d.ag_en, st_d.ra_en} = WDATA[2:0];
				end
				REG_RATES: begin
					st_d.basic = WDATA[11:0];
					st_d.night_rate = WDATA[27:16];
				end
				REG_SENSOR: begin
					st_d.msr = WDATA[11:0];
					st_d.thr = WDATA[19:12];
					st_d.gain = WDATA[23:20];
				end
				REG_STEPS: begin
					st_d.s_inc = WDATA[7:0];
					st_d.s_dec = WDATA[15:8];
					st_d.f_inc = WDATA[17:16];
					st_d.f_dec = WDATA[19:18];
				end
				REG_NIGHT: begin
					st_d.n_start = WDATA[10:0];
					st_d.n_end = WDATA[26:16];
				end
				REG_REFR: st_d.refr = WDATA[9:0];
				REG_TOD: st_d.tod = WDATA[10:0];
				REG_HYST: begin
					st_d.hyst = WDATA[11:0];
					st_d.night_hyst = WDATA[27:16];
				end
				default: begin
				end
			endcase
		end

		// read data stand only in the cycle after the strobe
		st_d.rdata = '0;
		if (RD) begin
			unique case (ADDR)
				REG_CTRL: st_d.rdata = {24'h000000, st_q.mode, st_q.night_en, st_q.stab_en,
					st_q.fade_en, st_q.ag_en, st_q.ra_en};
				REG_RATES: st_d.rdata = {4'h0, st_q.night_rate, 4'h0, st_q.basic};
				REG_SENSOR: st_d.rdata = {8'h00, st_q.gain, st_q.thr, st_q.msr};
				REG_STEPS: st_d.rdata = {12'h000, st_q.f_dec, st_q.f_inc, st_q.s_dec,
					st_q.s_inc};
				REG_NIGHT: st_d.rdata = {5'h00, st_q.n_end, 5'h00, st_q.n_start};
				REG_REFR: st_d.rdata = {22'h000000, st_q.refr};
				REG_TOD: st_d.rdata = {21'h000000, st_q.tod};
				REG_STAT: st_d.rdata = {2'h0, msw, st_q.night, st_q.backup, st_q.smooth,
					st_q.run_cnt, st_q.rate};
				REG_STAT2: st_d.rdata = {4'h0, st_q.atr_rate, 4'h0, sens};
				REG_HYST: st_d.rdata = {4'h0, st_q.night_hyst, 4'h0, st_q.hyst};
				default: st_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			st_q <= '0;
			st_q.basic <= BASIC_RST;
			st_q.night_rate <= NIGHT_RATE_RST;
			st_q.msr <= MSR_RST;
			st_q.thr <= THR_RST;
			st_q.gain <= GAIN_RST;
			st_q.s_inc <= SINC_RST;
			st_q.s_dec <= SDEC_RST;
			st_q.refr <= REFR_RST;
			st_q.n_start <= NSTART_RST;
			st_q.n_end <= NEND_RST;
			st_q.rate <= BASIC_RST;
			st_q.backup <= BASIC_RST;
			st_q.target <= BASIC_RST;
			st_q.div_st <= DIV_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign RDATA = st_q.rdata;
	assign ATRIAL_PACED_EVENT = st_q.pace_a;
	assign VENT_PACED_EVENT = st_q.pace_v;
	assign NIGHT_ACTIVE = st_q.night;
endmodule

// File: tb/pcr_rate_ctrl_sva.sv
// port assertions for the pacing rate controller
`timescale 1ns/1ps
module pcr_rate_ctrl_sva import pcr_pkg::*; #(
	parameter int unsigned CYC_PER_MS = CYC_PER_MS_DFLT
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_B,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [31:0] RDATA,
	// events
	input wire logic VENT_SENSED_EVENT,
	input wire logic ATRIAL_PACED_EVENT,
	input wire logic VENT_PACED_EVENT,
	input wire logic NIGHT_ACTIVE
);
	// no escape interval at a 12 bit rate can be shorter than this
	localparam int unsigned MIN_GAP = 140 * CYC_PER_MS;
	localparam int unsigned MAX_GAP = 2000 * CYC_PER_MS;
	logic [2:0] mode_q;
	logic night_en_q;
	logic [9:0] refr_q;
	logic [2:0] off_q;
	logic vs_q;
	int unsigned vgap_q;
	int unsigned since_q;
	int unsigned quiet_q;
	logic sense_ok;
	// margin of two ms covers tick alignment and the sync delay
	assign sense_ok = (mode_q == 3'h0 || mode_q > 3'h4) && VENT_SENSED_EVENT && !vs_q
		&& (since_q > (refr_q + 2) * CYC_PER_MS);
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			mode_q <= 3'h0;
			night_en_q <= 1'b0;
			refr_q <= REFR_RST;
			off_q <= 3'h0;
			vs_q <= 1'b0;
			vgap_q <= 0;
			since_q <= 0;
			quiet_q <= 0;
		end else begin
			if (WR && ADDR == REG_CTRL) begin
				mode_q <= WDATA[7:5];
				night_en_q <= WDATA[4];
			end
			if (WR && ADDR == REG_REFR) begin
				refr_q <= WDATA[9:0];
			end
			off_q <= night_en_q ? 3'h0 : ((off_q == 3'h4) ? off_q : off_q + 3'h1);
			vs_q <= VENT_SENSED_EVENT;
			vgap_q <= VENT_PACED_EVENT ? 1 : vgap_q + 1;
			since_q <= (VENT_PACED_EVENT || (VENT_SENSED_EVENT && !vs_q)) ? 0 : since_q + 1;
			quiet_q <= sense_ok ? 1 : ((quiet_q != 0 && quiet_q < MIN_GAP) ? quiet_q + 1 : 0);
		end
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);
	property p_rdata_idle;
		!RD |=> RDATA == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
	property p_rd_answer;
		(WR && ADDR == REG_CTRL) ##1 (RD && ADDR == REG_CTRL) |=>
			RDATA[7:0] == $past(WDATA[7:0], 2) && RDATA[31:8] == 24'h0;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("control word read back wrong");
	property p_vpace_pulse;
		VENT_PACED_EVENT |=> !VENT_PACED_EVENT;
	endproperty
	a_vpace_pulse: assert property (p_vpace_pulse) else $error("vent pace too long");
	property p_apace_pulse;
		ATRIAL_PACED_EVENT |=> !ATRIAL_PACED_EVENT;
	endproperty
	a_apace_pulse: assert property (p_apace_pulse) else $error("atrial pace too long");
	property p_vpace_gap;
		VENT_PACED_EVENT |-> vgap_q >= MIN_GAP;
	endproperty
	a_vpace_gap: assert property (p_vpace_gap) else $error("vent paces too close");
	property p_sense_quiet;
		VENT_PACED_EVENT |-> quiet_q <= 6;
	endproperty
	a_sense_quiet: assert property (p_sense_quiet) else $error("pace after valid sense");
	property p_fixed_run;
		mode_q == 3'h3 |-> vgap_q <= MAX_GAP;
	endproperty
	a_fixed_run: assert property (p_fixed_run) else $error("fixed mode pacing stopped");
	property p_night_off;
		off_q == 3'h4 |-> !NIGHT_ACTIVE;
	endproperty
	a_night_off: assert property (p_night_off) else $error("night while disabled");
endmodule
bind pcr_rate_ctrl pcr_rate_ctrl_sva #(.CYC_PER_MS(CYC_PER_MS)) pcr_rate_ctrl_sva_inst (
	.CORE_CLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .VENT_SENSED_EVENT,
	.ATRIAL_PACED_EVENT, .VENT_PACED_EVENT, .NIGHT_ACTIVE
);

// File: tb/pcr_heart_model.sv
// detector model: one-cycle requests become sense pin pulses
`timescale 1ns/1ps
module pcr_heart_model (
	// clock
	input wire logic clk,
	// requests: atrial, premature atrial, ventricular, premature ventricular
	input wire logic [3:0] req,
	// detector pins in the same order
	output logic [3:0] pin
);
	logic [1:0] hold_q [4] = '{default: 2'h0};
	// three cycles high so the two-stage sync always catches the pulse
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (req[i]) begin
				hold_q[i] <= 2'h3;
			end else if (hold_q[i] != 2'h0) begin
				hold_q[i] <= hold_q[i] - 2'h1;
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin[i] = (hold_q[i] != 2'h0);
		end
	end
endmodule

// File: tb/pcr_rate_ctrl_bench.sv
// bench for the pacing rate controller
`timescale 1ns/1ps
module pcr_rate_ctrl_bench;
	import pcr_pkg::*;
	localparam int unsigned CPM = 4;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [3:0] req = 4'h0;
	logic [3:0] pin;
	logic [7:0] act = 8'h00;
	logic msw = 1'b0;
	logic apace;
	logic vpace;
	logic night;
	int miscompares = 0;
	int checks_done = 0;
	int n;
	logic [31:0] d;
	always #10 clk = ~clk;
	pcr_heart_model pcr_heart_model_inst (.clk(clk), .req(req), .pin(pin));
	pcr_rate_ctrl #(.CYC_PER_MS(CPM)) pcr_rate_ctrl_inst (
		.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .ATRIAL_SENSED_EVENT(pin[0]), .ATRIAL_PREMATURE_EVENT(pin[1]),
		.VENT_SENSED_EVENT(pin[2]), .PREMATURE_VENT_EVENT(pin[3]),
		.MODE_SWITCH_ACTIVE(msw), .POST_MODE_SWITCH_ACTIVE(1'b0), .POST_SHOCK_ACTIVE(1'b0),
		.ACTIVITY_LEVEL(act), .ATRIAL_PACED_EVENT(apace), .VENT_PACED_EVENT(vpace),
		.NIGHT_ACTIVE(night)
	);
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// cycle counts may drift by the ms tick and the sync stages
	task automatic near(input int got, input int exp, input string what);
		checks_done++;
		if (got < exp - 8 || got > exp + 8) begin
			miscompares++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
		@(posedge clk);
	endtask
	task automatic wait_pace(input logic atr, output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (((atr ? apace : vpace) !== 1'b1) && c < 20000);
		if (c >= 20000) begin
			miscompares++;
			final_report();
		end
	endtask
	task automatic fire(input int i);
		req[i] <= 1'b1;
		@(posedge clk);
		req <= 4'h0;
	endtask
	task automatic t_regs();
		rd_reg(REG_RATES, d);
		check(d, {4'h0, NIGHT_RATE_RST, 4'h0, BASIC_RST}, "rates");
		rd_reg(REG_SENSOR, d);
		check(d, {8'h0, GAIN_RST, THR_RST, MSR_RST}, "sensor");
		rd_reg(REG_STEPS, d);
		check(d, {16'h0, SDEC_RST, SINC_RST}, "steps");
		rd_reg(8'h3C, d);
		check(d, 32'h0, "unmapped");
		addr <= REG_CTRL;
		wdata <= 32'hFFFF_FF40;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, 32'h40, "ctrl");
		@(posedge clk);
		wr_reg(REG_CTRL, 32'h0);
	endtask
	task automatic t_basic();
		wait_pace(1'b0, n);
		wait_pace(1'b0, n);
		near(n, 1000 * CPM, "basic interval");
	endtask
	task automatic t_sense();
		wait_pace(1'b0, n);
		repeat (500 * CPM) @(posedge clk);
		fire(2);
		repeat (100 * CPM - 1) @(posedge clk);
		fire(2);
		wait_pace(1'b0, n);
		near(n, 900 * CPM + 4, "sense restart");
	endtask
	task automatic t_fixed();
		wr_reg(REG_CTRL, {24'h0, MODE_FIXED_RATE_VENTRICULAR, 5'h0});
		wait_pace(1'b0, n);
		repeat (500 * CPM) @(posedge clk);
		fire(2);
		wait_pace(1'b0, n);
		near(n, 500 * CPM - 1, "fixed rate");
		wr_reg(REG_CTRL, {24'h0, MODE_FIXED_RATE_DUAL_CHAMBER, 5'h0});
		wait_pace(1'b1, n);
		check({31'h0, vpace}, 32'h1, "fixed dual pair");
	endtask
	task automatic t_atrial();
		for (int m = 1; m < 3; m++) begin
			wr_reg(REG_CTRL, {24'h0, m[2:0], 5'h0});
			wait_pace(1'b1, n);
			repeat (500 * CPM) @(posedge clk);
			fire((m == 1) ? 0 : 3);
			wait_pace(1'b1, n);
			near(n, 1000 * CPM + 4, "atrial restart");
		end
	endtask
	task automatic t_sensor();
		wr_reg(REG_CTRL, 32'h0);
		act <= 8'hFF;
		wait_pace(1'b0, n);
		wr_reg(REG_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		rd_reg(REG_STAT2, d);
		check(d[11:0], MSR_RST, "clamp");
		wait_pace(1'b0, n);
		rd_reg(REG_STAT, d);
		check(d[11:0], BASIC_RST + 12'(SINC_RST), "step");
		act <= THR_RST;
		repeat (10) @(posedge clk);
		rd_reg(REG_STAT2, d);
		check(d[11:0], BASIC_RST, "threshold");
		act <= THR_RST + 8'h05;
		repeat (10) @(posedge clk);
		rd_reg(REG_STAT2, d);
		check(d[11:0], 12'h26C, "sensor rate");
	endtask
	task automatic t_night();
		act <= THR_RST + 8'h01;
		wr_reg(REG_TOD, {21'h0, NSTART_RST});
		wr_reg(REG_CTRL, 32'h11);
		repeat (10) @(posedge clk);
		check({31'h0, night}, 32'h1, "night on");
		rd_reg(REG_STAT2, d);
		check(d[11:0], NIGHT_RATE_RST, "night threshold");
		rd_reg(REG_STAT, d);
		check({31'h0, d[15]}, 32'h1, "smoothing");
		wr_reg(REG_TOD, {21'h0, NEND_RST});
		repeat (10) @(posedge clk);
		check({31'h0, night}, 32'h0, "night off");
		rd_reg(REG_STAT2, d);
		check(d[11:0], 12'h25C, "day rate");
	endtask
	task automatic t_switch();
		wr_reg(REG_CTRL, {24'h0, MODE_DUAL, 5'h08});
		msw <= 1'b1;
		wait_pace(1'b0, n);
		wait_pace(1'b0, n);
		near(n, 1000 * CPM, "switch pacing");
		rd_reg(REG_STAT, d);
		check({31'h0, d[29]}, 32'h1, "switch flag");
		msw <= 1'b0;
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_basic();
		t_sense();
		t_fixed();
		t_atrial();
		t_sensor();
		t_night();
		t_switch();
		final_report();
	end
endmodule
